// *** spi_channel_config_upper.sv ***
// How it works
// - configuration reads 60000h after reset: input select and line-1 disable set.
// - both transmit disables set in transmit-receive mode is unsupported; flagged, lines idle.
// - every legal input-select and disable combination works as programmed.
// - granularity bit 29 clear divides by powers of two, set steps single cycles.
// - with single-cycle steps ratio is one more than extension concatenated with divider value, to 4096.
// - receive FIFO bit 28 routes received data to the buffer; one channel only, but exclusivity across channels is left to software.
// - input select clear samples data line 0, set samples data line 1.
// - a clear transmit disable drives that line while the channel is enabled and not receive-only; a set one keeps it quiet.
`include "spi_channel_config_upper_params.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_channel_config_upper #(
    parameter int ADR_W = 12
) (
    input  wire logic             clock_i,       // 40 MHz functional clock
    input  wire logic             resetn_i,      // async reset, active low
    input  wire logic             wb_cyc_i,      // wishbone cycle
    input  wire logic             wb_stb_i,      // wishbone strobe
    input  wire logic             wb_we_i,       // wishbone write
    input  wire logic [ADR_W-1:0] wb_adr_i,      // byte address
    input  wire logic [3:0]       wb_sel_i,      // byte enables
    input  wire logic [31:0]      wb_dat_i,      // write data
    output logic      [31:0]      wb_dat_o,      // read data
    output logic                  wb_ack_o,      // wishbone acknowledge
    input  wire logic             tx_bit_i,      // serial transmit bit from shifter
    input  wire logic [1:0]       line_in_i,     // serial_data_line levels
    output logic      [1:0]       line_out_o,    // serial_data_line drive values
    output logic      [1:0]       line_oe_o,     // serial_data_line output enables
    output logic                  rx_bit_o,      // sampled receive bit
    output logic                  rx_fifo_route_o, // receive data goes through buffer
    output logic                  div_tick_o,    // one-cycle channel clock enable
    output logic                  unsupported_o  // illegal line combination programmed
);

    spi_channel_config_upper_pkg::state_t state_reg;
    spi_channel_config_upper_pkg::state_t state_next;

    logic [31:0] sel_mask;
    logic [31:0] rd_mux;
    logic        access;
    logic        conf_wr;
    logic        ctrl_wr;
    logic [31:0] conf_new;
    logic [31:0] ctrl_new;
    logic        dis0;
    logic        dis1;
    logic        in_sel;
    logic        gran;
    logic        ch_en;
    logic [1:0]  transfer_direction_mode;
    logic [3:0]  div_val;
    logic [7:0]  div_ext;
    logic [15:0] pow2_m1;
    logic [15:0] ratio_m1;
    logic [15:0] div_cnt_next;
    logic        tick_next;
    logic        div_wrap;
    logic        rx_only;
    logic        tx_allowed;
    logic        bad_combo;
    logic [1:0]  line_dis;
    logic [1:0]  line_oe_next;
    logic [1:0]  line_out_next;

    // one byte lane per select bit; a clear select leaves that byte alone
    for (genvar b = 0; b < 4; b++)
    begin : g_lane
        assign sel_mask[8*b +: 8] = {8{wb_sel_i[b]}};
    end

    // ack blocks a second take while the master still holds its strobe
    assign access   = wb_cyc_i & wb_stb_i & ~state_reg.ack;
    assign conf_wr  = access & wb_we_i & (wb_adr_i == ADR_W'(`CONF_OFFSET));
    assign ctrl_wr  = access & wb_we_i & (wb_adr_i == ADR_W'(`CTRL_OFFSET));
    // reserved bits hold zero whatever is written
    assign conf_new = (state_reg.conf & ~(sel_mask & `CONF_WMASK))
                    | (wb_dat_i & sel_mask & `CONF_WMASK);
    assign ctrl_new = (state_reg.ctrl & ~(sel_mask & `CTRL_WMASK))
                    | (wb_dat_i & sel_mask & `CTRL_WMASK);

    assign dis0    = state_reg.conf[`LINE0_DIS_BIT];
    assign dis1    = state_reg.conf[`LINE1_DIS_BIT];
    assign in_sel  = state_reg.conf[`IN_SEL_BIT];
    assign gran    = state_reg.conf[`DIV_GRAN_BIT];
    assign transfer_direction_mode     = state_reg.conf[`TRM_MSB:`TRM_LSB];
    assign div_val = state_reg.conf[`DIV_VAL_MSB:`DIV_VAL_LSB];
    assign div_ext = state_reg.ctrl[`DIV_EXT_MSB:`DIV_EXT_LSB];
    assign ch_en   = state_reg.ctrl[`CH_ENABLE_BIT];
    // disable bits side by side, line 1 above line 0
    assign line_dis = {dis1, dis0};

    // both lines disabled leaves nothing to transmit on
    assign bad_combo  = (transfer_direction_mode == `TRM_TX_RX) & dis0 & dis1;
    // receive-only mode never drives a line
    assign rx_only    = (transfer_direction_mode == `TRM_RX_ONLY);
    assign tx_allowed = ch_en & ~rx_only & ~bad_combo;

    // each line is driven independently of the other
    for (genvar k = 0; k < 2; k++)
    begin : g_line
        assign line_oe_next[k]  = tx_allowed & ~line_dis[k];
        assign line_out_next[k] = tx_bit_i & ~line_dis[k];
    end

    // 17-bit shift so a divider value of 15 survives the subtraction
    assign pow2_m1 = 16'((17'h1 << div_val) - 17'h1);

    always_comb
    begin
        if (gran)
        begin
            ratio_m1 = {4'h0, div_ext, div_val};
        end
        else
        begin
            ratio_m1 = pow2_m1;
        end
    end

    // a ratio lowered mid-count wraps at once instead of running past it
    assign div_wrap = (state_reg.div_cnt >= ratio_m1);

    // divider restarts while the channel is off so the first tick is a full period
    always_comb
    begin
        div_cnt_next = 16'h0;
        tick_next    = 1'b0;
        if (ch_en && div_wrap)
        begin
            tick_next = 1'b1;
        end
        else if (ch_en)
        begin
            div_cnt_next = state_reg.div_cnt + 16'h1;
        end
    end

    always_comb
    begin
        case (wb_adr_i)
            ADR_W'(`CONF_OFFSET):
            begin
                rd_mux = state_reg.conf & `CONF_WMASK;
            end
            ADR_W'(`CTRL_OFFSET):
            begin
                rd_mux = state_reg.ctrl & `CTRL_WMASK;
            end
            // status is read-only; line levels are live, not registered
            ADR_W'(`STAT_OFFSET):
            begin
                rd_mux = {28'h0, state_reg.unsupported, state_reg.rx_bit, line_in_i};
            end
            default:
            begin
                rd_mux = 32'h0;
            end
        endcase
    end

    always_comb
    begin
        state_next       = state_reg;
        state_next.ack   = access;
        if (access)
        begin
            state_next.rdata = rd_mux;
        end
        else
        begin
            state_next.rdata = 32'h0;
        end

        if (conf_wr)
        begin
            state_next.conf = conf_new;
        end
        if (ctrl_wr)
        begin
            state_next.ctrl = ctrl_new;
        end

        state_next.div_cnt     = div_cnt_next;
        state_next.tick        = tick_next;
        state_next.line_oe     = line_oe_next;
        state_next.line_out    = line_out_next;
        state_next.rx_bit      = in_sel ? line_in_i[1] : line_in_i[0];
        // exclusivity across channels is left to software
        state_next.rx_fifo_route = state_reg.conf[`RX_FIFO_EN_BIT];
        state_next.unsupported = bad_combo;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state_reg               <= '0;
            state_reg.conf          <= `CONF_RESET;
            state_reg.ctrl          <= `CTRL_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign wb_dat_o        = state_reg.rdata;
    assign wb_ack_o        = state_reg.ack;
    assign line_out_o      = state_reg.line_out;
    assign line_oe_o       = state_reg.line_oe;
    assign rx_bit_o        = state_reg.rx_bit;
    assign rx_fifo_route_o = state_reg.rx_fifo_route;
    assign div_tick_o      = state_reg.tick;
    assign unsupported_o   = state_reg.unsupported;

endmodule

`default_nettype wire

// *** spi_channel_config_upper_params.svh ***
`ifndef SPI_CHANNEL_CONFIG_UPPER_PARAMS_SVH
`define SPI_CHANNEL_CONFIG_UPPER_PARAMS_SVH

// register byte offsets
`define CONF_OFFSET       12'h12c
`define CTRL_OFFSET       12'h134
`define STAT_OFFSET       12'h138

// reset values
`define CONF_RESET        32'h0006_0000
`define CTRL_RESET        32'h0000_0000
// writable bits of channel_configuration, reserved ones excluded
`define CONF_WMASK        32'h381f_ffff
// writable bits of channel_control
`define CTRL_WMASK        32'h0000_ff01

// channel_configuration field positions
`define DIV_GRAN_BIT      29
`define RX_FIFO_EN_BIT    28
`define IN_SEL_BIT        18
`define LINE1_DIS_BIT     17
`define LINE0_DIS_BIT     16
`define TRM_LSB           12
`define TRM_MSB           13
`define DIV_VAL_LSB       2
`define DIV_VAL_MSB       5

// channel_control field positions
`define CH_ENABLE_BIT     0
`define DIV_EXT_LSB       8
`define DIV_EXT_MSB       15

// transfer_direction_mode encodings
`define TRM_TX_RX         2'h0
`define TRM_RX_ONLY       2'h1
`define TRM_TX_ONLY       2'h2

`endif

// *** spi_channel_config_upper_pkg.sv ***
`default_nettype none

package spi_channel_config_upper_pkg;

    typedef struct packed {
        logic [31:0] conf;
        logic [31:0] ctrl;
        logic        ack;
        logic [31:0] rdata;
        logic [15:0] div_cnt;
        logic        tick;
        logic [1:0]  line_out;
        logic [1:0]  line_oe;
        logic        rx_bit;
        logic        rx_fifo_route;
        logic        unsupported;
    } state_t;

endpackage

`default_nettype wire

// *** spi_conf_checker_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_conf_checker (
    input wire logic        clock_i,         // clock
    input wire logic        resetn_i,        // reset
    input wire logic        wb_cyc_i,        // cycle
    input wire logic        wb_stb_i,        // strobe
    input wire logic        wb_ack_o,        // ack
    input wire logic [31:0] wb_dat_o,        // read data
    input wire logic        tx_bit_i,        // tx bit
    input wire logic [1:0]  line_in_i,       // line levels
    input wire logic [1:0]  line_out_o,      // drive values
    input wire logic [1:0]  line_oe_o,       // enables
    input wire logic        rx_bit_o,        // rx sample
    input wire logic        rx_fifo_route_o, // buffer route
    input wire logic        unsupported_o    // bad combo
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!resetn_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    a_bus_ack: assert property (s_req |=> s_ack_pulse)
        else $error("ack not a single pulse");
    a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_rx_low: assert property ($past(line_in_i) == 2'h0 |-> !rx_bit_o)
        else $error("rx high with both lines low");
    a_rx_high: assert property ($past(line_in_i) == 2'h3 |-> rx_bit_o)
        else $error("rx low with both lines high");
    a_line0_drive: assert property (line_oe_o[0] |-> line_out_o[0] == $past(tx_bit_i))
        else $error("line 0 not carrying tx");
    a_line1_drive: assert property (line_oe_o[1] |-> line_out_o[1] == $past(tx_bit_i))
        else $error("line 1 not carrying tx");
    a_unsup_quiet: assert property (unsupported_o |-> line_oe_o == 2'h0)
        else $error("line driven in bad combo");
    // outputs may only move one cycle after a register write
    a_cfg_on_write: assert property ($changed({rx_fifo_route_o, unsupported_o, line_oe_o})
        |-> $past(wb_ack_o))
        else $error("outputs moved without write");
endmodule
bind spi_channel_config_upper spi_conf_checker u_chk (.clock_i, .resetn_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_dat_o, .tx_bit_i, .line_in_i, .line_out_o, .line_oe_o,
    .rx_bit_o, .rx_fifo_route_o, .unsupported_o);
`default_nettype wire

// *** spi_line_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module spi_line_peer (
    input  wire logic [1:0] oe_i,   // device enables
    input  wire logic [1:0] dev_i,  // device values
    input  wire logic [1:0] data_i, // peer data
    output logic      [1:0] line_o  // wire levels
);
    // peer fills every line the device leaves free, so none floats
    assign line_o = (oe_i & dev_i) | (~oe_i & data_i);
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spi_channel_config_upper_params.svh"
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top;
    logic        clock_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, tx = 1'b0, f;
    logic [11:0] adr = 12'h0;
    logic [3:0]  sel = 4'hf;
    logic [31:0] dat = 32'h0, rd, q;
    logic        ack, rx, route, tick, bad;
    logic [1:0]  pdat = 2'h0, line, lout, loe;
    logic [1:0]  eo, el;
    int          n_errors = 0, comparisons = 0, n, i;
    integer      seed = 32'hb3bbee63;
    logic        g [3] = '{1'b0, 1'b1, 1'b1};
    logic [3:0]  v [3] = '{4'h3, 4'hf, 4'h1};
    logic [7:0]  e [3] = '{8'h00, 8'hff, 8'h00};
    always #12.5 clock_i = ~clock_i;
    spi_channel_config_upper DUT (.clock_i, .resetn_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd),
        .wb_ack_o(ack), .tx_bit_i(tx), .line_in_i(line), .line_out_o(lout),
        .line_oe_o(loe), .rx_bit_o(rx), .rx_fifo_route_o(route), .div_tick_o(tick),
        .unsupported_o(bad));
    spi_line_peer peer (.oe_i(loe), .dev_i(lout), .data_i(pdat), .line_o(line));
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do
            @(posedge clock_i);
        while (ack !== 1'b1 && ++k < 40);
        `CHK("ack", 1'b1, ack)
        q = rd;
        {cyc, stb} <= 2'b00;
        @(posedge clock_i);
    endtask
    function automatic int ratio(logic gr, logic [3:0] dv, logic [7:0] ex);
        return gr ? {ex, dv} + 1 : 1 << dv;
    endfunction
    task report_and_stop;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        repeat (12) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        wb(1'b0, `CONF_OFFSET, 32'h0);
        `CHK("conf reset", `CONF_RESET, q)
        wb(1'b0, `CTRL_OFFSET, 32'h0);
        `CHK("ctrl reset", `CTRL_RESET, q)
        wb(1'b1, `CONF_OFFSET, 32'hffff_ffff);
        wb(1'b0, `CONF_OFFSET, 32'h0);
        `CHK("conf mask", `CONF_WMASK, q)
        sel <= 4'h1;
        wb(1'b1, `CONF_OFFSET, 32'h0);
        sel <= 4'hf;
        wb(1'b0, `CONF_OFFSET, 32'h0);
        `CHK("conf lanes", `CONF_WMASK & 32'hffff_ff00, q)
        wb(1'b0, 12'h200, 32'h0);
        `CHK("unmapped", 32'h0, q)
        wb(1'b1, `CTRL_OFFSET, 32'h1);
        for (i = 0; i < 8; i++)
        begin
            f = 1'($random(seed));
            tx <= 1'($random(seed));
            pdat <= 2'($random(seed));
            wb(1'b1, `CONF_OFFSET, {3'h0, f, 9'h0, 3'(i), 16'h0});
            repeat (2) @(posedge clock_i);
            eo = (i[1:0] == 2'h3) ? 2'h0 : ~i[1:0];
            el = (eo & {tx, tx}) | (~eo & pdat);
            `CHK("oe", eo, loe)
            `CHK("out", eo & {tx, tx}, lout)
            `CHK("line", el, line)
            `CHK("unsup", i[1:0] == 2'h3, bad)
            `CHK("route", f, route)
            `CHK("rx", el[i[2]], rx)
            wb(1'b0, `STAT_OFFSET, 32'h0);
            `CHK("status", {28'h0, (i[1:0] == 2'h3), el[i[2]], el}, q)
        end
        for (i = 0; i < 3; i++)
        begin
            wb(1'b1, `CTRL_OFFSET, 32'h0);
            wb(1'b1, `CONF_OFFSET, {2'h0, g[i], 23'h0, v[i], 2'h0});
            wb(1'b1, `CTRL_OFFSET, {16'h0, e[i], 8'h1});
            for (n = 0; tick !== 1'b1 && n < 9000; n++)
                @(posedge clock_i);
            @(posedge clock_i);
            for (n = 1; tick !== 1'b1 && n < 9000; n++)
                @(posedge clock_i);
            `CHK("ratio", ratio(g[i], v[i], e[i]), n)
        end
        wb(1'b0, `CTRL_OFFSET, 32'h0);
        `CHK("ctrl", 32'h0000_0001, q)
        wb(1'b1, `CONF_OFFSET, 32'h0000_1000);
        repeat (2) @(posedge clock_i);
        `CHK("rx only oe", 2'h0, loe)
        wb(1'b1, `CTRL_OFFSET, 32'h0);
        wb(1'b1, `CONF_OFFSET, 32'h0);
        repeat (2) @(posedge clock_i);
        `CHK("off oe", 2'h0, loe)
        pdat <= 2'h0;
        resetn_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        `CHK("reset oe", 2'h0, loe)
        wb(1'b0, `CONF_OFFSET, 32'h0);
        `CHK("conf re-reset", `CONF_RESET, q)
        report_and_stop();
    end
endmodule
`default_nettype wire
